// ---- pkg/oag_pkg.sv ----
/*
  Shared constants, enumerations and the stack-alias lookup of the operand
  and address generator. Assumes a single core clock; the instruction
  decoder supplies already decoded fields and the register file supplies
  the base, index and shift-amount register values.
*/
package oag_pkg;
  localparam int DATA_W      = 32;
  localparam int IMM12_W     = 12;
  localparam int IMM8_W      = 8;
  localparam int SHIFT_IMM_W = 5;
  localparam int REG_AMT_W   = 8;
  localparam int COUNT_W     = 5;
  localparam int WORD_SHIFT  = 2;
  localparam logic [DATA_W-1:0] WORD_STEP  = 32'h0000_0004;
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    CLASS_DATA_PROC, CLASS_WORD_BYTE, CLASS_HALF_SBYTE, CLASS_MULTI,
    CLASS_COPRO
  } oag_class_t;

  typedef enum logic [1:0] {
    INDEX_OFFSET, INDEX_PRE, INDEX_POST
  } oag_index_t;

  typedef enum logic [1:0] {
    SRC_IMM, SRC_REG, SRC_SCALED
  } oag_src_t;

  typedef enum logic [2:0] {
    SHIFT_LEFT_LOGICAL, SHIFT_RIGHT_LOGICAL, SHIFT_RIGHT_ARITH,
    ROTATE_RIGHT, ROTATE_RIGHT_EXTEND
  } oag_shift_t;

  typedef enum logic [1:0] {
    INC_AFTER, INC_BEFORE, DEC_AFTER, DEC_BEFORE
  } oag_multi_t;

  typedef enum logic [1:0] {
    FULL_DESC_STACK, EMPTY_DESC_STACK, FULL_ASC_STACK, EMPTY_ASC_STACK
  } oag_stack_t;

  // Separate tables for loads and stores keep the two aliases independent.
  function automatic oag_multi_t stack_to_multi(input oag_stack_t s,
                                                input logic       isLoad);
    oag_multi_t m;
    m = INC_AFTER;
    if (isLoad) begin
      case (s)
        FULL_DESC_STACK:  m = INC_AFTER;
        EMPTY_DESC_STACK: m = INC_BEFORE;
        FULL_ASC_STACK:   m = DEC_AFTER;
        default:          m = DEC_BEFORE;
      endcase
    end else begin
      case (s)
        FULL_DESC_STACK:  m = INC_AFTER;
        EMPTY_DESC_STACK: m = INC_BEFORE;
        FULL_ASC_STACK:   m = DEC_AFTER;
        default:          m = DEC_BEFORE;
      endcase
    end
    return m;
  endfunction
endpackage

// ---- pkg/oag_shift_if.sv ----
/*
  Carrier between the generator and its barrel shifter.
  Assumes both ends sit in the same core clock domain; it is purely
  combinational.
*/
`timescale 1ns/100ps
interface oag_shift_if;
  logic [oag_pkg::DATA_W-1:0]    value;
  logic [oag_pkg::REG_AMT_W-1:0] amount;
  oag_pkg::oag_shift_t           kind;
  logic                          carryIn;
  logic [oag_pkg::DATA_W-1:0]    result;
  logic                          carryOut;

  modport requester (output value, amount, kind, carryIn,
                     input  result, carryOut);
  modport shifter   (input  value, amount, kind, carryIn,
                     output result, carryOut);
endinterface

// ---- logic/oag_barrel_shifter.sv ----
/*
  Combinational barrel shifter with shifter carry out.
  Assumes the amount is already chosen by the caller: a 5-bit immediate
  zero-extended, or the low byte of the shift-amount register.
*/
`timescale 1ns/100ps
module oag_barrel_shifter (
  oag_shift_if.shifter sh
);
  localparam int W = oag_pkg::DATA_W;

  logic [2*W-1:0]        leftWide;
  logic [2*W-1:0]        rightWide;
  logic signed [2*W-1:0] arithWide;
  logic [W-1:0]          rotated;
  logic [4:0]            rotAmt;

  // Double-width shifts give the carry bit and the saturation past 32
  // for free, so amounts of 32 and above need no special case.
  always_comb begin
    leftWide  = {{W{1'b0}}, sh.value} << sh.amount;
    rightWide = {sh.value, {W{1'b0}}} >> sh.amount;
    arithWide = $signed({sh.value, {W{1'b0}}}) >>> sh.amount;
    rotAmt    = sh.amount[4:0];
    rotated   = (sh.value >> rotAmt) | (sh.value << (6'd32 - {1'b0, rotAmt}));
  end

  // For every kind but rotate-right-extend, an amount of zero passes the value and the carry flag unchanged.
  always_comb begin
    sh.result   = sh.value;
    sh.carryOut = sh.carryIn;
    case (sh.kind)
      oag_pkg::SHIFT_LEFT_LOGICAL: if (sh.amount != '0) begin
        sh.result   = leftWide[W-1:0];
        sh.carryOut = leftWide[W];
      end
      oag_pkg::SHIFT_RIGHT_LOGICAL: if (sh.amount != '0) begin
        sh.result   = rightWide[2*W-1:W];
        sh.carryOut = rightWide[W-1];
      end
      oag_pkg::SHIFT_RIGHT_ARITH: if (sh.amount != '0) begin
        sh.result   = arithWide[2*W-1:W];
        sh.carryOut = arithWide[W-1];
      end
      oag_pkg::ROTATE_RIGHT: if (sh.amount != '0) begin
        sh.result   = rotated;
        sh.carryOut = rotated[W-1];
      end
      oag_pkg::ROTATE_RIGHT_EXTEND: begin
        sh.result   = {sh.carryIn, sh.value[W-1:1]};
        sh.carryOut = sh.value[0];
      end
      default: begin
        sh.result   = sh.value;
        sh.carryOut = sh.carryIn;
      end
    endcase
  end
endmodule

// ---- logic/oag_operand_address_generator.sv ----
/*
  Operand and address generator: second data-processing operand, shifter
  carry, transfer address and base write-back value, one cycle after a
  request. Assumes decoded fields arrive with reqValid from the decoder
  and register values are stable in the same cycle.
*/
`timescale 1ns/100ps
module oag_operand_address_generator (
  input  logic                              clk,
  input  logic                              reset_n,
  input  logic                              reqValid,
  input  oag_pkg::oag_class_t               addrClass,
  input  oag_pkg::oag_index_t               indexMode,
  input  oag_pkg::oag_src_t                 offsetSource,
  input  logic                              offsetUp,
  input  logic                              userPriv,
  input  logic [oag_pkg::IMM12_W-1:0]       immOffset,
  input  oag_pkg::oag_shift_t               shiftKind,
  input  logic [oag_pkg::SHIFT_IMM_W-1:0]   shiftImm,
  input  logic                              shiftByReg,
  input  logic                              useImm,
  input  logic [oag_pkg::DATA_W-1:0]        imm32,
  input  logic [oag_pkg::DATA_W-1:0]        baseReg,
  input  logic [oag_pkg::DATA_W-1:0]        indexReg,
  input  logic [oag_pkg::DATA_W-1:0]        shiftAmountReg,
  input  logic                              carryFlag,
  input  oag_pkg::oag_multi_t               multiMode,
  input  logic                              useStackAlias,
  input  oag_pkg::oag_stack_t               stackType,
  input  logic                              multiLoad,
  input  logic [oag_pkg::COUNT_W-1:0]       regCount,
  output logic                              resultValid_q,
  output logic [oag_pkg::DATA_W-1:0]        operand2_q,
  output logic                              shifterCarry_q,
  output logic [oag_pkg::DATA_W-1:0]        xferAddr_q,
  output logic [oag_pkg::DATA_W-1:0]        writebackAddr_q,
  output logic                              writebackEn_q,
  output logic                              userAccess_q,
  output logic                              modeError_q
);
  oag_shift_if shIf ();

  logic [oag_pkg::DATA_W-1:0] offset;
  logic [oag_pkg::DATA_W-1:0] indexed;
  logic [oag_pkg::DATA_W-1:0] span;
  logic [oag_pkg::DATA_W-1:0] addr_d;
  logic [oag_pkg::DATA_W-1:0] wback_d;
  logic                       wbEn_d;
  logic                       err_d;
  logic [oag_pkg::DATA_W-1:0] operand_d;
  logic                       carry_d;
  oag_pkg::oag_multi_t        seq;

  // Every check below runs on the core clock and sleeps through reset.
  default clocking chkClk @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  oag_barrel_shifter u_shifter (
    .sh (shIf.shifter)
  );

  // One shifter serves both the data-processing operand and the scaled
  // index; only one class is active per request, so sharing costs nothing.
  always_comb begin
    shIf.value   = indexReg;
    shIf.kind    = shiftKind;
    shIf.carryIn = carryFlag;
    if (addrClass == oag_pkg::CLASS_DATA_PROC && shiftByReg) begin
      shIf.amount = shiftAmountReg[oag_pkg::REG_AMT_W-1:0];
    end else begin
      shIf.amount = oag_pkg::REG_AMT_W'(shiftImm);
    end
  end

  // Second operand: immediate, or the shifted register; an immediate
  // keeps the carry flag as the shifter carry.
  always_comb begin
    if (useImm) begin
      operand_d = imm32;
      carry_d   = carryFlag;
    end else begin
      operand_d = shIf.result;
      carry_d   = shIf.carryOut;
    end
  end

  // Offset per class, and detection of forms a class does not offer.
  always_comb begin
    offset = '0;
    err_d  = 1'b0;
    case (addrClass)
      oag_pkg::CLASS_WORD_BYTE: begin
        case (offsetSource)
          oag_pkg::SRC_IMM: offset = oag_pkg::DATA_W'(immOffset);
          oag_pkg::SRC_REG:    offset = indexReg;
          default:             offset = shIf.result;
        endcase
        err_d = userPriv && indexMode == oag_pkg::INDEX_PRE;
      end
      oag_pkg::CLASS_HALF_SBYTE: begin
        // A scaled index is refused here but still added unshifted.
        if (offsetSource == oag_pkg::SRC_IMM) begin
          offset = oag_pkg::DATA_W'(
                     immOffset[oag_pkg::IMM8_W-1:0]);
        end else begin
          offset = indexReg;
        end
        err_d = offsetSource == oag_pkg::SRC_SCALED || userPriv;
      end
      oag_pkg::CLASS_COPRO: begin
        offset = oag_pkg::DATA_W'(immOffset[oag_pkg::IMM8_W-1:0])
                 << oag_pkg::WORD_SHIFT;
        err_d  = offsetSource != oag_pkg::SRC_IMM || userPriv;
      end
      oag_pkg::CLASS_MULTI:     err_d = userPriv;
      oag_pkg::CLASS_DATA_PROC: err_d = userPriv;
      default:                  err_d = 1'b1;
    endcase
  end

  // Block sequencing: the stack alias, when used, picks the sequence.
  always_comb begin
    seq  = useStackAlias ? oag_pkg::stack_to_multi(stackType, multiLoad)
                         : multiMode;
    span = oag_pkg::DATA_W'(regCount) << oag_pkg::WORD_SHIFT;
  end

  // Transfer address and write-back value for every class.
  always_comb begin
    indexed = offsetUp ? baseReg + offset : baseReg - offset;
    addr_d  = baseReg;
    wback_d = baseReg;
    wbEn_d  = 1'b0;
    case (addrClass)
      oag_pkg::CLASS_MULTI: begin
        wbEn_d = 1'b1;
        case (seq)
          oag_pkg::INC_AFTER: begin
            addr_d  = baseReg;
            wback_d = baseReg + span;
          end
          oag_pkg::INC_BEFORE: begin
            addr_d  = baseReg + oag_pkg::WORD_STEP;
            wback_d = baseReg + span;
          end
          oag_pkg::DEC_AFTER: begin
            addr_d  = baseReg - span + oag_pkg::WORD_STEP;
            wback_d = baseReg - span;
          end
          default: begin
            addr_d  = baseReg - span;
            wback_d = baseReg - span;
          end
        endcase
      end
      oag_pkg::CLASS_WORD_BYTE, oag_pkg::CLASS_HALF_SBYTE,
      oag_pkg::CLASS_COPRO: begin
        case (indexMode)
          oag_pkg::INDEX_PRE: begin
            addr_d  = indexed;
            wback_d = indexed;
            wbEn_d  = 1'b1;
          end
          oag_pkg::INDEX_POST: begin
            addr_d  = baseReg;
            wback_d = indexed;
            wbEn_d  = 1'b1;
          end
          default: addr_d = indexed;
        endcase
      end
      default: begin
        addr_d  = baseReg;
        wback_d = baseReg;
      end
    endcase
  end

  // Result strobe: exactly one cycle after each request.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resultValid_q <= 1'b0;
    end else begin
      resultValid_q <= reqValid;
    end
  end

  // Operand path registers; held between requests.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      operand2_q     <= oag_pkg::RESET_WORD;
      shifterCarry_q <= 1'b0;
    end else if (reqValid) begin
      operand2_q     <= operand_d;
      shifterCarry_q <= carry_d;
    end
  end

  // Address path registers. A refused form never writes the base back,
  // so a bad decode cannot corrupt the register file.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xferAddr_q      <= oag_pkg::RESET_WORD;
      writebackAddr_q <= oag_pkg::RESET_WORD;
      writebackEn_q   <= 1'b0;
      userAccess_q    <= 1'b0;
      modeError_q     <= 1'b0;
    end else if (reqValid) begin
      xferAddr_q      <= addr_d;
      writebackAddr_q <= wback_d;
      writebackEn_q   <= wbEn_d && !err_d;
      userAccess_q    <= userPriv && addrClass == oag_pkg::CLASS_WORD_BYTE;
      modeError_q     <= err_d;
    end else begin
      writebackEn_q   <= 1'b0;
    end
  end

  a_class_latency: assert property (
    reqValid |=> resultValid_q ##1 (resultValid_q == $past(reqValid)))
    else $error("result strobe not one cycle after request");

  a_imm12_offset: assert property (
    reqValid && addrClass == oag_pkg::CLASS_WORD_BYTE && offsetUp &&
    offsetSource == oag_pkg::SRC_IMM && indexMode == oag_pkg::INDEX_OFFSET
    |=> xferAddr_q == $past(baseReg) + {20'h0, $past(immOffset)})
    else $error("word immediate offset address wrong");

  a_scaled_index: assert property (
    reqValid && addrClass == oag_pkg::CLASS_WORD_BYTE && !offsetUp &&
    offsetSource == oag_pkg::SRC_SCALED && indexMode == oag_pkg::INDEX_OFFSET
    && shiftKind == oag_pkg::SHIFT_LEFT_LOGICAL
    |=> xferAddr_q == $past(baseReg) - ($past(indexReg) << $past(shiftImm)))
    else $error("scaled index address wrong");

  a_user_no_pre: assert property (
    reqValid && userPriv && indexMode == oag_pkg::INDEX_PRE
    |=> modeError_q && !writebackEn_q)
    else $error("user pre-indexed form not refused");

  a_half_imm8: assert property (
    reqValid && addrClass == oag_pkg::CLASS_HALF_SBYTE && !offsetUp &&
    offsetSource == oag_pkg::SRC_IMM && indexMode == oag_pkg::INDEX_OFFSET
    |=> xferAddr_q == $past(baseReg) - {24'h0, $past(immOffset[7:0])})
    else $error("halfword offset ignores the 8-bit limit");

  a_multi_span: assert property (
    reqValid && addrClass == oag_pkg::CLASS_MULTI && !useStackAlias &&
    multiMode == oag_pkg::DEC_BEFORE && !userPriv
    |=> writebackEn_q && xferAddr_q == writebackAddr_q &&
        writebackAddr_q == $past(baseReg) - {25'h0, $past(regCount), 2'b00}
    ##1 !writebackEn_q || resultValid_q)
    else $error("decrement-before block address wrong");

  a_copro_scale: assert property (
    reqValid && addrClass == oag_pkg::CLASS_COPRO && offsetUp &&
    offsetSource == oag_pkg::SRC_IMM && indexMode == oag_pkg::INDEX_OFFSET
    |=> xferAddr_q == $past(baseReg) + {22'h0, $past(immOffset[7:0]), 2'b00})
    else $error("coprocessor offset not scaled by four");

  a_dp_immediate: assert property (
    reqValid && addrClass == oag_pkg::CLASS_DATA_PROC && useImm
    |=> operand2_q == $past(imm32) && shifterCarry_q == $past(carryFlag))
    else $error("immediate operand not passed through");

  a_post_base: assert property (
    reqValid && addrClass != oag_pkg::CLASS_MULTI &&
    addrClass != oag_pkg::CLASS_DATA_PROC && indexMode == oag_pkg::INDEX_POST
    |=> xferAddr_q == $past(baseReg) &&
        writebackAddr_q == ($past(offsetUp) ? xferAddr_q + $past(offset)
                                            : xferAddr_q - $past(offset)))
    else $error("post-indexed transfer did not use the base");

  a_rrx_carry: assert property (
    reqValid && addrClass == oag_pkg::CLASS_DATA_PROC && !useImm &&
    shiftKind == oag_pkg::ROTATE_RIGHT_EXTEND
    |=> operand2_q[31] == $past(carryFlag) &&
        operand2_q[30:0] == $past(indexReg[31:1]) &&
        shifterCarry_q == $past(indexReg[0]))
    else $error("rotate-right-extended result or carry wrong");
endmodule

// ---- testbench/oag_core_model.sv ----
/*
  Model of the instruction decoder and register file that feed the operand
  and address generator. Assumes the bench sets the request fields between
  clock edges and calls fire; register values simply stand, as a register
  file's read ports do.
*/
`timescale 1ns/100ps
module oag_core_model (
  input  logic                            clk,
  output logic                            reqValid,
  output oag_pkg::oag_class_t             addrClass,
  output oag_pkg::oag_index_t             indexMode,
  output oag_pkg::oag_src_t               offsetSource,
  output logic                            offsetUp,
  output logic                            userPriv,
  output logic [oag_pkg::IMM12_W-1:0]     immOffset,
  output oag_pkg::oag_shift_t             shiftKind,
  output logic [oag_pkg::SHIFT_IMM_W-1:0] shiftImm,
  output logic                            shiftByReg,
  output logic                            useImm,
  output logic [oag_pkg::DATA_W-1:0]      imm32,
  output logic [oag_pkg::DATA_W-1:0]      baseReg,
  output logic [oag_pkg::DATA_W-1:0]      indexReg,
  output logic [oag_pkg::DATA_W-1:0]      shiftAmountReg,
  output logic                            carryFlag,
  output oag_pkg::oag_multi_t             multiMode,
  output logic                            useStackAlias,
  output oag_pkg::oag_stack_t             stackType,
  output logic                            multiLoad,
  output logic [oag_pkg::COUNT_W-1:0]     regCount
);
  // Neutral decode around the given class, base, immediate and block size;
  // the strobe is left alone so it is never driven twice.
  task automatic plain(input oag_pkg::oag_class_t          c,
                       input logic [oag_pkg::DATA_W-1:0]  b,
                       input logic [oag_pkg::IMM12_W-1:0] im,
                       input logic [oag_pkg::COUNT_W-1:0] n);
    addrClass = c;
    indexMode = oag_pkg::INDEX_OFFSET;
    offsetSource = oag_pkg::SRC_IMM;
    offsetUp = 1'b1;
    userPriv = 1'b0;
    immOffset = im;
    shiftKind = oag_pkg::SHIFT_LEFT_LOGICAL;
    shiftImm = 5'h00;
    shiftByReg = 1'b0;
    useImm = 1'b0;
    imm32 = 32'h0000_0000;
    baseReg = b;
    indexReg = 32'h0000_0000;
    shiftAmountReg = 32'h0000_0000;
    carryFlag = 1'b0;
    multiMode = oag_pkg::INC_AFTER;
    useStackAlias = 1'b0;
    stackType = oag_pkg::FULL_DESC_STACK;
    multiLoad = 1'b0;
    regCount = n;
  endtask

  // Keeping the strobe high lets the next request follow with no gap.
  task automatic fire(input logic keep);
    if (reqValid !== 1'b1) begin
      @(posedge clk);
      #1;
      reqValid = 1'b1;
    end
    @(posedge clk);
    #1;
    if (!keep) reqValid = 1'b0;
  endtask

  // Inputs hold a defined value from time zero.
  initial begin
    reqValid = 1'b0;
    plain(oag_pkg::CLASS_DATA_PROC, 32'h0, 12'h000, 5'h00);
  end
endmodule

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench of the operand and address generator.
  Assumes the core model drives every request field and that results
  stand one edge after the request is taken.
*/
`timescale 1ns/100ps
module tb_top;
  logic                            clk = 1'b0;
  logic                            reset_n = 1'b0;
  logic                            reqValid, offsetUp, userPriv, useImm;
  logic                            shiftByReg, carryFlag, multiLoad;
  logic                            useStackAlias;
  oag_pkg::oag_class_t             addrClass;
  oag_pkg::oag_index_t             indexMode;
  oag_pkg::oag_src_t               offsetSource;
  oag_pkg::oag_shift_t             shiftKind;
  oag_pkg::oag_multi_t             multiMode;
  oag_pkg::oag_stack_t             stackType;
  logic [oag_pkg::IMM12_W-1:0]     immOffset;
  logic [oag_pkg::SHIFT_IMM_W-1:0] shiftImm;
  logic [oag_pkg::COUNT_W-1:0]     regCount;
  logic [31:0]                     imm32, baseReg, indexReg, shiftAmountReg;
  logic                            resultValid_q, shifterCarry_q;
  logic                            writebackEn_q, userAccess_q, modeError_q;
  logic [31:0]                     operand2_q, xferAddr_q, writebackAddr_q;
  int                              nTests = 0;
  int                              failures = 0;
  int                              cycles = 0;

  oag_core_model P (.clk(clk), .reqValid(reqValid), .addrClass(addrClass),
    .indexMode(indexMode), .offsetSource(offsetSource),
    .offsetUp(offsetUp), .userPriv(userPriv), .immOffset(immOffset),
    .shiftKind(shiftKind), .shiftImm(shiftImm), .shiftByReg(shiftByReg),
    .useImm(useImm), .imm32(imm32), .baseReg(baseReg),
    .indexReg(indexReg), .shiftAmountReg(shiftAmountReg),
    .carryFlag(carryFlag), .multiMode(multiMode),
    .useStackAlias(useStackAlias), .stackType(stackType),
    .multiLoad(multiLoad), .regCount(regCount));

  oag_operand_address_generator DUT (.clk(clk), .reset_n(reset_n),
    .reqValid(reqValid), .addrClass(addrClass), .indexMode(indexMode),
    .offsetSource(offsetSource), .offsetUp(offsetUp),
    .userPriv(userPriv), .immOffset(immOffset), .shiftKind(shiftKind),
    .shiftImm(shiftImm), .shiftByReg(shiftByReg), .useImm(useImm),
    .imm32(imm32), .baseReg(baseReg), .indexReg(indexReg),
    .shiftAmountReg(shiftAmountReg), .carryFlag(carryFlag),
    .multiMode(multiMode), .useStackAlias(useStackAlias),
    .stackType(stackType), .multiLoad(multiLoad), .regCount(regCount),
    .resultValid_q(resultValid_q), .operand2_q(operand2_q),
    .shifterCarry_q(shifterCarry_q), .xferAddr_q(xferAddr_q),
    .writebackAddr_q(writebackAddr_q), .writebackEn_q(writebackEn_q),
    .userAccess_q(userAccess_q), .modeError_q(modeError_q));

  // Core clock of 100 ns.
  always #50 clk = ~clk;

  task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(string nm, logic e, logic g);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  // The new base is only judged when a write-back is due.
  task automatic xfer(string nm, logic [31:0] a, logic [31:0] w,
                      logic we, logic err);
    chk1({nm, " valid"}, 1'b1, resultValid_q);
    chk32({nm, " addr"}, a, xferAddr_q);
    if (we) chk32({nm, " wb"}, w, writebackAddr_q);
    chk1({nm, " wben"}, we, writebackEn_q);
    chk1({nm, " err"}, err, modeError_q);
  endtask

  task automatic s_word_imm();
    P.plain(oag_pkg::CLASS_WORD_BYTE, 32'h0000_1000, 12'hfff, 5'h00);
    P.fire(1'b1);
    xfer("wimm off", 32'h0000_1fff, 32'h0, 1'b0, 1'b0);
    P.indexMode = oag_pkg::INDEX_PRE;
    P.offsetUp = 1'b0;
    P.fire(1'b1);
    xfer("wimm pre", 32'h0000_0001, 32'h1, 1'b1, 1'b0);
    P.indexMode = oag_pkg::INDEX_POST;
    P.offsetUp = 1'b1;
    P.fire(1'b0);
    xfer("wimm post", 32'h1000, 32'h1fff, 1'b1, 1'b0);
    @(posedge clk);
    #1;
    chk1("wben drop", 1'b0, writebackEn_q);
  endtask

  // Every shift kind scales the index; rotate-extend pulls in the carry.
  task automatic s_word_shift();
    logic [4:0]  amt [5] = '{5'h04, 5'h1f, 5'h01, 5'h08, 5'h00};
    logic [31:0] idx [5] = '{32'h3, 32'h8000_0000, 32'h8000_0000,
                             32'h12, 32'h2};
    logic [31:0] ea  [5] = '{32'h0d0, 32'h101, 32'hc000_0100,
                             32'h1200_0100, 32'h8000_0101};
    P.plain(oag_pkg::CLASS_WORD_BYTE, 32'h0000_0100, 12'h000, 5'h00);
    P.offsetSource = oag_pkg::SRC_SCALED;
    P.carryFlag = 1'b1;
    for (int i = 0; i < 5; i++) begin
      P.shiftKind = oag_pkg::oag_shift_t'(i);
      P.offsetUp = (i != 0); // The left shift is subtracted.
      P.shiftImm = amt[i];
      P.indexReg = idx[i];
      P.fire(1'b1);
      xfer("wscaled", ea[i], 32'h0, 1'b0, 1'b0);
    end
    P.offsetSource = oag_pkg::SRC_REG;
    P.offsetUp = 1'b0;
    P.indexReg = 32'h0000_0020;
    P.fire(1'b0);
    xfer("wreg", 32'h0000_00e0, 32'h0, 1'b0, 1'b0);
  endtask

  task automatic s_user();
    P.plain(oag_pkg::CLASS_WORD_BYTE, 32'h0000_0200, 12'h010, 5'h00);
    P.userPriv = 1'b1;
    P.fire(1'b1);
    xfer("user off", 32'h210, 32'h0, 1'b0, 1'b0);
    chk1("user flag", 1'b1, userAccess_q);
    P.indexMode = oag_pkg::INDEX_POST;
    P.fire(1'b1);
    xfer("user post", 32'h200, 32'h210, 1'b1, 1'b0);
    P.indexMode = oag_pkg::INDEX_PRE;
    P.fire(1'b0);
    xfer("user pre", 32'h210, 32'h0, 1'b0, 1'b1);
  endtask

  task automatic s_half();
    P.plain(oag_pkg::CLASS_HALF_SBYTE, 32'h0000_0400, 12'hfff, 5'h00);
    P.offsetUp = 1'b0;
    P.fire(1'b1);
    xfer("half imm", 32'h301, 32'h0, 1'b0, 1'b0);
    P.offsetSource = oag_pkg::SRC_REG;
    P.indexMode = oag_pkg::INDEX_POST;
    P.indexReg = 32'h0000_0004;
    P.fire(1'b1);
    xfer("half reg", 32'h400, 32'h3fc, 1'b1, 1'b0);
    P.offsetSource = oag_pkg::SRC_SCALED;
    P.fire(1'b0);
    xfer("half scaled", 32'h400, 32'h0, 1'b0, 1'b1);
  endtask

  // Unused class codes are refused as well.
  task automatic s_copro();
    P.plain(oag_pkg::CLASS_COPRO, 32'h0000_1000, 12'hf40, 5'h00);
    P.offsetUp = 1'b0;
    P.indexMode = oag_pkg::INDEX_PRE;
    P.fire(1'b1);
    xfer("copro pre", 32'hf00, 32'hf00, 1'b1, 1'b0);
    P.offsetUp = 1'b1;
    P.indexMode = oag_pkg::INDEX_OFFSET;
    P.fire(1'b1);
    xfer("copro off", 32'h1100, 32'h0, 1'b0, 1'b0);
    P.offsetSource = oag_pkg::SRC_REG;
    P.indexMode = oag_pkg::INDEX_POST;
    P.fire(1'b1);
    xfer("copro reg", 32'h1000, 32'h0, 1'b0, 1'b1);
    P.addrClass = oag_pkg::oag_class_t'(3'h5);
    P.fire(1'b0);
    chk1("bad class", 1'b1, modeError_q);
  endtask

  // Sixteen registers; aliases map in the same order for both tables.
  task automatic s_multi();
    logic [31:0] ea [4] = '{32'h1000, 32'h1004, 32'h0fc4, 32'h0fc0};
    logic [31:0] ew [4] = '{32'h1040, 32'h1040, 32'h0fc0, 32'h0fc0};
    P.plain(oag_pkg::CLASS_MULTI, 32'h0000_1000, 12'h000, 5'h10);
    for (int i = 0; i < 4; i++) begin
      P.multiMode = oag_pkg::oag_multi_t'(i);
      P.fire(1'b1);
      xfer("multi", ea[i], ew[i], 1'b1, 1'b0);
    end
    P.useStackAlias = 1'b1;
    for (int l = 0; l < 2; l++) begin
      for (int i = 0; i < 4; i++) begin
        P.multiLoad = l[0];
        P.stackType = oag_pkg::oag_stack_t'(i);
        P.multiMode = oag_pkg::oag_multi_t'(3 - i);
        P.fire(1'b1);
        xfer("stack", ea[i], ew[i], 1'b1, 1'b0);
      end
    end
    // The user variant belongs to word transfers only.
    P.userPriv = 1'b1;
    P.fire(1'b0);
    xfer("multi user", 32'h0fc0, 32'h0, 1'b0, 1'b1);
    chk1("multi user flag", 1'b0, userAccess_q);
  endtask

  task automatic dp(string nm, logic ui, logic sbr, oag_pkg::oag_shift_t k,
                    logic [4:0] si, logic [31:0] sa, logic [31:0] v,
                    logic cf, logic [31:0] eo, logic ec, logic keep);
    P.useImm = ui;
    P.shiftByReg = sbr;
    P.shiftKind = k;
    P.shiftImm = si;
    P.shiftAmountReg = sa;
    P.imm32 = v;
    P.indexReg = v;
    P.carryFlag = cf;
    P.fire(keep);
    chk1({nm, " valid"}, 1'b1, resultValid_q);
    chk32({nm, " op"}, eo, operand2_q);
    chk1({nm, " carry"}, ec, shifterCarry_q);
    chk1({nm, " wben"}, 1'b0, writebackEn_q);
  endtask

  task automatic s_data_proc();
    P.plain(oag_pkg::CLASS_DATA_PROC, 32'h0, 12'h000, 5'h00);
    dp("imm", 1, 0, oag_pkg::SHIFT_LEFT_LOGICAL, 5'h00, 32'h0,
       32'h0000_00ff, 1, 32'h0000_00ff, 1, 1);
    dp("reg", 0, 0, oag_pkg::SHIFT_LEFT_LOGICAL, 5'h00, 32'h0,
       32'h1234_5678, 1, 32'h1234_5678, 1, 1);
    dp("lsr imm", 0, 0, oag_pkg::SHIFT_RIGHT_LOGICAL, 5'h04, 32'h0,
       32'h0000_00f8, 0, 32'h0000_000f, 1, 1);
    dp("asr reg", 0, 1, oag_pkg::SHIFT_RIGHT_ARITH, 5'h00, 32'h24,
       32'h8000_0000, 0, 32'hffff_ffff, 1, 1);
    dp("ror reg", 0, 1, oag_pkg::ROTATE_RIGHT, 5'h00, 32'h8,
       32'h0000_00a5, 0, 32'ha500_0000, 1, 1);
    dp("rrx", 0, 0, oag_pkg::ROTATE_RIGHT_EXTEND, 5'h00, 32'h0,
       32'h0000_0002, 1, 32'h8000_0001, 0, 0);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the fewer than a hundred cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      conclude();
    end
  end

  // Reset for 20 cycles, then the scenarios in turn.
  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk1("idle valid", 1'b0, resultValid_q);
    s_word_imm();
    s_word_shift();
    s_user();
    s_half();
    s_copro();
    s_multi();
    s_data_proc();
    conclude();
  end
endmodule
